//--- hdl/swel_core.sv
`timescale 1ns/1ps
// How it works
// (R1) LAN wake events raise remote wake only in suspend level 0.
// (R2) Energy detect raises remote wake only in suspend level 1.
// (R3) Good frame raises remote wake only in suspend level 3.
// (R4) Resume in all levels, link up in 0 and 3, unpowered: bus power.
// (R5) Configured pins 0 to 10 may wake in any suspend level, except pin 7 with link-up select.
// (R6) A pin wake event sets that pin's flag in irq_status.
// (R7) Host clears pending wake flags before suspend, else instant wake.
// (R8) Pins 0 to 7 wake only with internal PHY; 8 to 10 with either PHY.
// (R9) Pin 7 acts like 0 to 6, plus link up when selected.
// (R10) Composite LAN wake ORs each detected event gated by its enable.
// (R11) Wake interrupt from LAN composite with enable, or PHY irq with enable.
// (R12) Two wake status bits: LAN frame and energy, set by their events.
// (R13) Seen flags record pattern, magic, perfect address and broadcast.
// (R14) Host enables MAC wake detection and PHY energy irq beforehand.
// (R15) Asserted wake interrupt drives remote wake when suspended.
// (R16) Good frame counts only with all LAN enables clear; enable ignored.
// (R17) Good frame raises wake interrupt and sets the LAN status bit.
// (R18) Pins 0-7 have a gate bit; 8-10 gate derives from pin mode.
// (R19) Suspend select 00..11 for levels 0..3, default level 2.
// (R20) With link-up select, pin 7's external signal is ignored.
// (R21) LAN status bit refuses to clear while MAC wake event stands.
// (R22) Sources sampled on core clock; reset clears all wake flags.
module swel_core
	import swel_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        suspended,
	input  wire logic        unpowered,
	input  wire logic        host_resume,
	input  wire logic        bus_power_detect,
	input  wire logic        unicast_evt,
	input  wire logic        magic_evt,
	input  wire logic        pattern_evt,
	input  wire logic        perfect_da_evt,
	input  wire logic        broadcast_evt,
	input  wire logic        good_frame_evt,
	input  wire logic        phy_irq,
	input  wire logic        phy_link_up,
	input  wire logic [10:0] pin_in,
	output logic             wake_irq,
	output logic             remote_wake,
	output logic             wake_request
);
	swel_state_t s;
	swel_state_t n;
	swel_level_t lvl;
	logic [4:0]  lan_evts;
	logic [4:0]  lan_hits;
	logic        lan_comp;
	logic        good;
	logic        mac_evt;
	logic        susp_ok;
	logic        wr;
	logic [10:0] gate_ok;
	logic [10:0] pin_src;
	logic [10:0] pin_evt;
	logic [10:0] pin_ok;
	logic        lan_term;
	logic        ed_term;
	logic        good_term;
	logic        pin_term;
	logic [1:0]  clr_ws;
	logic [4:0]  clr_seen;
	logic [10:0] clr_pin;
	logic [31:0] rd;

	function automatic logic hit(input logic [31:0] a,
		input logic [31:0] off);
		hit = (a == off);
	endfunction

	// hsize is not decoded: only whole-word transfers are expected
	assign hreadyout = !(s.dsel && !s.dwr && !s.rvalid);
	assign hresp     = 1'b0;
	assign hrdata    = s.rdata;
	assign wake_irq     = s.irq;
	assign remote_wake  = s.rwake;
	assign wake_request = s.wreq;

	assign lvl      = swel_level_t'(s.susp_sel);
	assign susp_ok  = suspended && !unpowered;
	assign lan_evts = {broadcast_evt, perfect_da_evt, pattern_evt,
		magic_evt, unicast_evt};
	assign lan_hits = lan_evts & s.lwc_en;                     // [R10]
	assign lan_comp = |lan_hits;                               // [R10]
	assign good     = good_frame_evt && !(|s.lwc_en);          // [R16]
	assign mac_evt  = lan_comp || good;

	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		if (i < NGATED) begin : g_low
			// Low pins share balls with the internal PHY mode only
			assign gate_ok[i] = !s.gate[i] && !s.ext_phy;      // [R8] [R18]
		end else begin : g_high
			localparam int B = (i - NGATED) * IPC_STRIDE;
			assign gate_ok[i] = (s.ipc[B +: 2] == 2'h0)
				&& !s.ipc[B + IPC_DIR_OFS];                    // [R18]
		end
		if (i == LINK_PIN) begin : g_link
			// Pin level is ignored once link up drives this wake
			assign pin_src[i] = s.link_sel ? phy_link_up
				: (pin_in[i] ^ s.pol[i]);                      // [R9] [R20]
			assign pin_ok[i] = !s.link_sel
				|| lvl == suspend_level0
				|| lvl == suspend_level3;                      // [R4]
		end else begin : g_plain
			assign pin_src[i] = pin_in[i] ^ s.pol[i];
			assign pin_ok[i]  = 1'b1;
		end
		assign pin_evt[i] = pin_src[i] && s.wk_en[i] && gate_ok[i];
	end

	// Wake terms act on sticky status, so a flag left set wakes at once
	// The LAN status bit is shared with good frames; the enables tell them apart
	assign lan_term  = lvl == suspend_level0 && s.wstat[WS_LAN]
		&& (|s.lwc_en)
		&& s.lan_en;                                           // [R1] [R11] [R7]
	assign ed_term   = lvl == suspend_level1 && s.wstat[WS_ENERGY]
		&& s.energy_wake_enable;                                            // [R2] [R11]
	assign good_term = lvl == suspend_level3 && !(|s.lwc_en) // [R16]
		&& s.wstat[WS_LAN];                                    // [R3] [R17]
	assign pin_term  = |(s.pin_flag & s.wk_en & pin_ok);       // [R5]

	always_comb begin
		n = s;
		wr = s.dsel && s.dwr;
		clr_ws = 2'h0;
		clr_seen = 5'h0;
		clr_pin = 11'h0;
		rd = 32'h0;
		if (hready) begin
			n.dsel  = hsel && htrans[1];
			n.dwr   = hwrite;
			n.daddr = haddr;
		end
		n.rvalid = s.dsel && !s.dwr && !s.rvalid;
		if (wr && hit(s.daddr, OFF_PMC)) begin
			n.susp_sel = hwdata[PMC_SEL_LO +: 2];             // [R19]
			n.lan_en   = hwdata[PMC_LAN_EN];
			n.energy_wake_enable    = hwdata[PMC_ENERGY_WAKE_ENABLE];
			clr_ws     = hwdata[PMC_WS_LO +: 2];
		end
		if (wr && hit(s.daddr, OFF_LWC)) begin
			n.lwc_en = hwdata[LWC_EN_LO +: NEV];
			clr_seen = hwdata[LWC_SEEN_LO +: NEV];
		end
		if (wr && hit(s.daddr, OFF_IRQ))
			clr_pin = hwdata[NPINS-1:0];
		if (wr && hit(s.daddr, OFF_PCFG))
			n.gate = hwdata[NGATED-1:0];
		if (wr && hit(s.daddr, OFF_PWAKE)) begin
			n.wk_en    = hwdata[PW_WK_LO +: NPINS];
			n.pol      = hwdata[PW_POL_LO +: NPINS];
			n.link_sel = hwdata[PW_LINK_SEL];
		end
		if (wr && hit(s.daddr, OFF_IPC))
			n.ipc = hwdata[11:0];
		if (wr && hit(s.daddr, OFF_HWC))
			n.ext_phy = hwdata[HWC_EXT_PHY];
		// Live events block the clear; a set always beats a clear
		clr_ws[WS_LAN]    = clr_ws[WS_LAN] && !mac_evt;       // [R21]
		clr_ws[WS_ENERGY] = clr_ws[WS_ENERGY] && !phy_irq;
		n.wstat = s.wstat & ~clr_ws;
		n.wstat[WS_LAN]    = n.wstat[WS_LAN] || mac_evt;      // [R12] [R17]
		n.wstat[WS_ENERGY] = n.wstat[WS_ENERGY] || phy_irq;   // [R12]
		// Unicast has no seen flag; its slot stays zero
		n.seen = ((s.seen & ~clr_seen) | lan_hits)
			& 5'h1e;                                           // [R13]
		n.pin_flag = (s.pin_flag & ~clr_pin) | pin_evt;       // [R6]
		n.irq   = lan_term || ed_term || good_term || pin_term;
		n.rwake = n.irq && susp_ok;                            // [R15]
		n.wreq  = n.rwake || (susp_ok && host_resume)
			|| (unpowered && bus_power_detect);                // [R4]
		if (hit(s.daddr, OFF_PMC)) begin
			rd[PMC_SEL_LO +: 2] = s.susp_sel;
			rd[PMC_LAN_EN]      = s.lan_en;
			rd[PMC_ENERGY_WAKE_ENABLE]       = s.energy_wake_enable;
			rd[PMC_WS_LO +: 2]  = s.wstat;
		end
		if (hit(s.daddr, OFF_LWC)) begin
			rd[LWC_EN_LO +: NEV]   = s.lwc_en;
			rd[LWC_SEEN_LO +: NEV] = s.seen;
		end
		if (hit(s.daddr, OFF_IRQ))
			rd[NPINS-1:0] = s.pin_flag;
		if (hit(s.daddr, OFF_PCFG))
			rd[NGATED-1:0] = s.gate;
		if (hit(s.daddr, OFF_PWAKE)) begin
			rd[PW_WK_LO +: NPINS]  = s.wk_en;
			rd[PW_POL_LO +: NPINS] = s.pol;
			rd[PW_LINK_SEL]        = s.link_sel;
		end
		if (hit(s.daddr, OFF_IPC))
			rd[11:0] = s.ipc;
		if (hit(s.daddr, OFF_HWC))
			rd[HWC_EXT_PHY] = s.ext_phy;
		// Read data is taken a cycle late so a prior write is visible
		if (n.rvalid)
			n.rdata = rd;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s          <= '0;                                  // [R22]
			s.susp_sel <= SUSP_SEL_RST;                        // [R19]
			s.gate     <= GATE_RST;
		end else begin
			s <= n;                                            // [R22]
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence lan_armed_l0;
		susp_ok && lvl == suspend_level0 && s.wstat[WS_LAN] && s.lan_en
		&& (|s.lwc_en);
	endsequence
	sequence pattern_hit;
		pattern_evt && s.lwc_en[EV_PAT];
	endsequence

	a_lan_wake_l0: assert property (lan_armed_l0 |=> remote_wake) // [R1]
		else $error("LAN wake in level 0 did not raise remote wake");
	a_energy_wake_l1: assert property (                        // [R2]
		susp_ok && lvl == suspend_level1 && s.wstat[WS_ENERGY]
		&& s.energy_wake_enable |=> remote_wake && wake_irq)
		else $error("energy wake in level 1 missing");
	a_good_frame_l3: assert property (                         // [R3]
		susp_ok && lvl == suspend_level3 && s.wstat[WS_LAN]
		&& !(|s.lwc_en) |=> remote_wake)
		else $error("good frame wake in level 3 missing");
	a_level2_quiet: assert property (                          // [R4]
		lvl == suspend_level2 && !(|(s.pin_flag & s.wk_en))
		|=> !wake_irq)
		else $error("level 2 woke without a pin");
	a_resume_request: assert property (                        // [R4]
		(susp_ok && host_resume) || (unpowered && bus_power_detect)
		|=> wake_request)
		else $error("resume or bus power did not request wake");
	a_pin_flag_set: assert property (                          // [R6]
		pin_evt != 11'h0 |=> (s.pin_flag & $past(pin_evt))
		== $past(pin_evt))
		else $error("pin wake flag not set");
	a_ext_phy_block: assert property (                         // [R8]
		s.ext_phy |=> (s.pin_flag[7:0] & ~$past(s.pin_flag[7:0]))
		== 8'h0)
		else $error("low pin flagged with external PHY");
	a_lan_sticky: assert property (                            // [R21]
		s.wstat[WS_LAN] && mac_evt |=> s.wstat[WS_LAN])
		else $error("LAN status cleared while event stands");
	a_seen_record: assert property (pattern_hit |=> s.seen[EV_PAT])
		else $error("pattern frame seen flag not set");         // [R13]
	a_unpowered_mute: assert property (                        // [R4]
		unpowered |=> !remote_wake)
		else $error("remote wake while unpowered");

	sequence link_armed;
		s.link_sel && phy_link_up && s.wk_en[LINK_PIN]
		&& !s.gate[LINK_PIN] && !s.ext_phy;
	endsequence

	a_energy_off_level: assert property (                      // [R2]
		lvl != suspend_level1 && !s.wstat[WS_LAN]
		&& !(|(s.pin_flag & s.wk_en)) |=> !wake_irq)
		else $error("energy wake outside level 1");
	a_link_up_flag: assert property (link_armed                // [R9]
		|=> s.pin_flag[LINK_PIN])
		else $error("link up did not flag pin 7");
	a_link_pin_mute: assert property (                         // [R20]
		s.link_sel && !phy_link_up && !s.pin_flag[LINK_PIN]
		|=> !s.pin_flag[LINK_PIN])
		else $error("pin 7 level used while link up selected");
	a_high_pin_gate: assert property (                         // [R18]
		(s.ipc[IPC_DIR_OFS-1:0] != 2'h0 || s.ipc[IPC_DIR_OFS])
		&& !s.pin_flag[NGATED] |=> !s.pin_flag[NGATED])
		else $error("pin 8 woke while not an input");
	a_pin_any_level: assert property (                         // [R5]
		susp_ok && (s.pin_flag & s.wk_en & 11'h77f) != 11'h0
		|=> remote_wake)
		else $error("pin wake ignored in this level");
	a_remote_suspend: assert property (                        // [R15]
		susp_ok |=> remote_wake == wake_irq)
		else $error("wake interrupt did not reach remote wake");
	a_remote_awake: assert property (                          // [R15]
		!suspended |=> !remote_wake)
		else $error("remote wake while not suspended");
	a_good_frame_set: assert property (                        // [R17]
		good_frame_evt && !(|s.lwc_en) |=> s.wstat[WS_LAN])
		else $error("good frame did not set LAN status");
	a_energy_status: assert property (                         // [R12]
		phy_irq |=> s.wstat[WS_ENERGY])
		else $error("energy status not set");
	a_lan_gated: assert property (                             // [R10]
		!s.wstat[WS_LAN] && (lan_evts & s.lwc_en) == 5'h0
		&& !good_frame_evt |=> !s.wstat[WS_LAN])
		else $error("LAN status set by a disabled event");
endmodule

//--- hdl/swel_pkg.sv
package swel_pkg;
	localparam int NPINS        = 11;
	localparam int NGATED       = 8;
	localparam int LINK_PIN     = 7;
	localparam int NEV          = 5;
	// Register byte offsets
	localparam logic [31:0] OFF_PMC   = 32'h0000_0000;
	localparam logic [31:0] OFF_LWC   = 32'h0000_0004;
	localparam logic [31:0] OFF_IRQ   = 32'h0000_0008;
	localparam logic [31:0] OFF_PCFG  = 32'h0000_000c;
	localparam logic [31:0] OFF_PWAKE = 32'h0000_0010;
	localparam logic [31:0] OFF_IPC   = 32'h0000_0014;
	localparam logic [31:0] OFF_HWC   = 32'h0000_0018;
	// power_mgmt_ctl fields
	localparam int PMC_SEL_LO   = 0;
	localparam int PMC_LAN_EN   = 4;
	localparam int PMC_ENERGY_WAKE_ENABLE    = 5;
	localparam int PMC_WS_LO    = 8;
	localparam int WS_ENERGY    = 0;
	localparam int WS_LAN       = 1;
	// lan_wake_ctl_sts fields, event index shared by enables and seen flags
	localparam int LWC_EN_LO    = 0;
	localparam int LWC_SEEN_LO  = 8;
	localparam int EV_UNI       = 0;
	localparam int EV_MAG       = 1;
	localparam int EV_PAT       = 2;
	localparam int EV_PDA       = 3;
	localparam int EV_BC        = 4;
	// Pin wake enable / polarity register fields
	localparam int PW_WK_LO     = 0;
	localparam int PW_POL_LO    = 16;
	localparam int PW_LINK_SEL  = 31;
	// indicator_pin_config: per pin 8..10 a 2-bit mode and a direction bit
	localparam int IPC_STRIDE   = 4;
	localparam int IPC_DIR_OFS  = 2;
	// hardware_config fields
	localparam int HWC_EXT_PHY  = 0;
	// Reset values
	localparam logic [1:0]  SUSP_SEL_RST = 2'h2;
	localparam logic [7:0]  GATE_RST     = 8'hff;

	typedef enum logic [1:0] {
		suspend_level0 = 2'h0,
		suspend_level1 = 2'h1,
		suspend_level2 = 2'h2,
		suspend_level3 = 2'h3
	} swel_level_t;

	typedef struct packed {
		logic        dsel;
		logic        dwr;
		logic [31:0] daddr;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  susp_sel;
		logic        lan_en;
		logic        energy_wake_enable;
		logic [1:0]  wstat;
		logic [4:0]  lwc_en;
		logic [4:0]  seen;
		logic [10:0] pin_flag;
		logic [7:0]  gate;
		logic [10:0] wk_en;
		logic [10:0] pol;
		logic        link_sel;
		logic [11:0] ipc;
		logic        ext_phy;
		logic        irq;
		logic        rwake;
		logic        wreq;
	} swel_state_t;
endpackage

//--- sim/swel_host_model.sv
`timescale 1ns/1ps
// Host side: registers suspend requests onto the suspended output and answers a
// remote wake with resume signalling after DLY cycles (DLY from 1 to 256).
module swel_host_model #(
	parameter int DLY = 4
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic want_suspend,
	input  wire logic remote_wake,
	output logic      suspended,
	output logic      host_resume
);
	logic [7:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			suspended   <= 1'b0;
			host_resume <= 1'b0;
			cnt         <= 8'h00;
		end else begin
			suspended   <= want_suspend;
			cnt         <= remote_wake ? cnt + 8'h01 : 8'h00;
			// One pulse every 256 cycles while remote wake holds, as cnt wraps
			host_resume <= remote_wake && (cnt == 8'(DLY - 1));
		end
	end
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb
	import swel_pkg::*;
;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
	logic [1:0]  htrans = 0;
	logic        hreadyout, hresp, unpowered = 0, bus_power_detect = 0;
	logic        phy_irq = 0, phy_link_up = 0, want_suspend = 0;
	logic        suspended, host_resume, wake_irq, remote_wake, wake_request;
	logic [5:0]  ev = 0;
	logic [10:0] pin_in = 0;
	int          miscompares = 0, total_checks = 0, cyc = 0;
	swel_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .suspended(suspended),
		.unpowered(unpowered), .host_resume(host_resume),
		.bus_power_detect(bus_power_detect), .unicast_evt(ev[0]),
		.magic_evt(ev[1]), .pattern_evt(ev[2]), .perfect_da_evt(ev[3]),
		.broadcast_evt(ev[4]), .good_frame_evt(ev[5]), .phy_irq(phy_irq),
		.phy_link_up(phy_link_up), .pin_in(pin_in), .wake_irq(wake_irq),
		.remote_wake(remote_wake), .wake_request(wake_request));
	swel_host_model #(.DLY(6)) host (.hclk(hclk), .hresetn(hresetn),
		.want_suspend(want_suspend), .remote_wake(remote_wake),
		.suspended(suspended), .host_resume(host_resume));
	initial begin
		forever #5 hclk = ~hclk;
	end
	task automatic end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic [31:0] a, d, input logic w);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [31:0] a, d);
		bus(a, d, 1'b1);
	endtask
	task automatic rd(input logic [31:0] a, e);
		bus(a, 32'h0, 1'b0);
		chk("hrdata", v, e);
	endtask
	task automatic rw(input logic e);
		repeat (3) @(posedge hclk);
		#1 chk("remote_wake", {31'h0, remote_wake}, {31'h0, e});
		chk("wake_irq", {31'h0, wake_irq}, {31'h0, e});
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFF_PMC, 32'h2);
		rd(OFF_PCFG, 32'hff);
		rd(32'h20, 32'h0);
		wr(OFF_PCFG, 32'h0);
		for (int s = 0; s < 3; s++) begin
			for (int l = 0; l < 4; l++) begin
				wr(OFF_LWC, (s == 0) ? 32'h4 : 32'h0);
				wr(OFF_PMC, 32'h330 | l);
				want_suspend <= 1'b1;
				ev[2]   <= (s == 0);
				phy_irq <= (s == 1);
				ev[5]   <= (s == 2);
				@(posedge hclk);
				ev      <= 6'h0;
				phy_irq <= 1'b0;
				rw(l == ((s == 2) ? 3 : s));
				rd(OFF_PMC, 32'h30 | l | ((s == 1) ? 32'h100 : 32'h200));
				want_suspend <= 1'b0;
			end
		end
		wr(OFF_LWC, 32'h4);
		ev[2] <= 1'b1;
		wr(OFF_PMC, 32'h302);
		rd(OFF_PMC, 32'h202);
		rd(OFF_LWC, 32'h404);
		ev[2] <= 1'b0;
		wr(OFF_LWC, 32'h400);
		wr(OFF_PMC, 32'h302);
		rd(OFF_PMC, 32'h2);
		wr(OFF_IPC, 32'h1);
		wr(OFF_PWAKE, 32'h100);
		want_suspend <= 1'b1;
		pin_in[8] <= 1'b1;
		rw(1'b0);
		wr(OFF_IPC, 32'h0);
		rw(1'b1);
		rd(OFF_IRQ, 32'h100);
		#1 chk("wake_request", {31'h0, wake_request}, 32'h1);
		pin_in[8] <= 1'b0;
		wr(OFF_IRQ, 32'h7ff);
		wr(OFF_HWC, 32'h1);
		wr(OFF_PWAKE, 32'h8);
		pin_in[3] <= 1'b1;
		rw(1'b0);
		pin_in[3] <= 1'b0;
		wr(OFF_PWAKE, 32'h8000_0080);
		wr(OFF_HWC, 32'h0);
		wr(OFF_PMC, 32'h0);
		pin_in[7] <= 1'b1;
		rw(1'b0);
		phy_link_up <= 1'b1;
		rw(1'b1);
		rd(OFF_IRQ, 32'h80);
		unpowered <= 1'b1;
		bus_power_detect <= 1'b1;
		repeat (2) @(posedge hclk);
		#1 chk("remote_wake", {31'h0, remote_wake}, 32'h0);
		chk("wake_request", {31'h0, wake_request}, 32'h1);
		hresetn <= 1'b0;
		unpowered <= 1'b0;
		bus_power_detect <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFF_IRQ, 32'h0);
		rd(OFF_PMC, 32'h2);
		#1 chk("remote_wake", {31'h0, remote_wake}, 32'h0);
		end_sim;
	end
endmodule
